/* hdl/hpsc_consts.vh */
// register offsets, field positions and reset values of the slot power registers
`ifndef HPSC_CONSTS_VH
`define HPSC_CONSTS_VH
`define HPSC_OFS_CTRL_A     8'h02
`define HPSC_OFS_CTRL_B     8'h03
`define HPSC_OFS_COND_A     8'h04
`define HPSC_OFS_COND_B     8'h05
`define HPSC_CTRL_RESET     8'h00
`define HPSC_COND_RESET     8'h00
`define HPSC_CTRL_AUX_EN    0
`define HPSC_CTRL_PRI_EN    1
`define HPSC_CTRL_GATE      2
`define HPSC_CTRL_PRI_GOOD  6
`define HPSC_CTRL_AUX_GOOD  7
`define HPSC_COND_LV_OC     0
`define HPSC_COND_HV_OC     2
`define HPSC_COND_AUX_OC    4
`define HPSC_COND_AUX_ON    5
`define HPSC_COND_PRI_ON    6
`define HPSC_COND_TRIP      7
`endif

/* hdl/hpsc_slot.v */
// per-slot control, overcurrent flags, trip latch and pin logic
`include "hpsc_consts.vh"
`default_nettype none
module hpsc_slot (
   input  wire       clock_in,
   input  wire       rst_in,
   input  wire       ctrl_wr_in,
   input  wire       cond_wr_in,
   input  wire [7:0] wdata_in,
   input  wire       aux_good_in,
   input  wire       pri_good_in,
   input  wire       aux_on_in,
   input  wire       pri_on_in,
   input  wire       aux_oc_in,
   input  wire       hv_oc_in,
   input  wire       lv_oc_in,
   input  wire       override_n_in,
   input  wire       power_request_in,
   input  wire       aux_request_in,
   output wire [7:0] ctrl_out,
   output wire [7:0] cond_out,
   output wire       aux_enable_out,
   output wire       primary_enable_out,
   output wire       flag_any_out,
   output reg        ok_oe_n_out,
   output reg        trip_oe_n_out
);
   reg  [2:0] ctrl;
   reg  [2:0] oc;
   reg        trip_pri;
   reg        trip_aux;
   wire [2:0] oc_event;
   wire [2:0] oc_clear;
   wire       hw_mode;
   wire       override_act;
   wire       trip;
   wire       next_ok_oe_n;
   wire       next_trip_oe_n;

   assign oc_event = {aux_oc_in, hv_oc_in, lv_oc_in};
   assign oc_clear = {wdata_in[`HPSC_COND_AUX_OC], wdata_in[`HPSC_COND_HV_OC],
                      wdata_in[`HPSC_COND_LV_OC]} & {3{cond_wr_in}};
   // pins tied low means serial management control: no trip latching
   assign hw_mode      = power_request_in | aux_request_in; // RULE14
   assign override_act = ~override_n_in & ~ctrl[`HPSC_CTRL_GATE]; // RULE2
   assign trip         = trip_pri | trip_aux;

   always @(posedge clock_in)
   begin
      if (rst_in)
      begin
         ctrl     <= 3'h0; // RULE4
         oc       <= 3'h0; // RULE4
         trip_pri <= 1'b0;
         trip_aux <= 1'b0;
      end
      else
      begin
         // only writable bits stored; read-only and reserved writes dropped
         if (ctrl_wr_in)
            ctrl <= wdata_in[2:0]; // RULE1 RULE16
         // set wins over a same-cycle echo clear
         oc <= (oc & ~oc_clear) | oc_event; // RULE10 RULE11
         // trip latches held until the matching request drops
         if (hw_mode & (hv_oc_in | lv_oc_in))
            trip_pri <= 1'b1;
         else if (~power_request_in)
            trip_pri <= 1'b0; // RULE13
         if (hw_mode & aux_oc_in)
            trip_aux <= 1'b1;
         else if (~aux_request_in)
            trip_aux <= 1'b0; // RULE13
      end
   end

   // power-good released when override active, else AND of flags
   assign next_ok_oe_n   = override_act ? 1'b1 : ~(aux_good_in & pri_good_in); // RULE5 RULE6
   // trip pin released while override, independent of reads or clears
   assign next_trip_oe_n = ~(trip & ~override_act); // RULE12 RULE15

   always @(posedge clock_in)
   begin
      if (rst_in)
      begin
         ok_oe_n_out   <= 1'b1;
         trip_oe_n_out <= 1'b1;
      end
      else
      begin
         ok_oe_n_out   <= next_ok_oe_n;
         trip_oe_n_out <= next_trip_oe_n;
      end
   end

   // power-good bits report true state, unaffected by override
   assign ctrl_out = {aux_good_in, pri_good_in, 3'h0, ctrl}; // RULE3 RULE7 RULE16
   // status trip bit follows latch even while the pin is released by override
   assign cond_out = {trip, pri_on_in, aux_on_in, oc[2], 1'b0, oc[1], 1'b0, oc[0]}; // RULE8 RULE9 RULE15
   assign aux_enable_out     = ctrl[`HPSC_CTRL_AUX_EN];
   assign primary_enable_out = ctrl[`HPSC_CTRL_PRI_EN];
   assign flag_any_out       = |oc;
endmodule
`default_nettype wire

/* hdl/hpsc_sync.v */
// two flip-flop synchroniser for a group of pin levels
`default_nettype none
module hpsc_sync #(
   parameter WIDTH = 1
) (
   input  wire             clock_in,
   input  wire             rst_in,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta;
   always @(posedge clock_in)
   begin
      if (rst_in)
      begin
         meta     <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

/* hdl/hpsc_top.v */
// dual-slot hot plug control and status register bank
//
// Contract
// RULE1 - control bit 0 switches aux output, bit 1 main outputs; both writable
// RULE2 - control bit 2 set makes the override pin be ignored
// RULE3 - control bits 7 and 6 read aux and main power-good
// RULE4 - all control and status registers reset to zero, outputs off
// RULE5 - power-ok pin is AND of both good flags unless override
// RULE6 - override low with gate clear releases the power-ok pin
// RULE7 - power-good register bits unaffected by override
// RULE8 - status bit 7 reads 1 while trip pin is driven low
// RULE9 - status bits 6 and 5 show main and aux actual on state
// RULE10 - status bits 4, 2, 0 latch aux, 12 V, 3.3 V overcurrent
// RULE11 - writing one clears an overcurrent flag and drops the alert
// RULE12 - reads and flag clears never change the trip pin
// RULE13 - trip pin releases only when the matching request inputs go low
// RULE14 - requests tied low means serial control: trip bit and pin inactive
// RULE15 - override releases trip pin; trip status bit still reports
// RULE16 - writes to read-only or reserved bits ignored, reserved read zero
// RULE17 - alert pin works only while the mask input is 0
`include "hpsc_consts.vh"
`default_nettype none
module hpsc_top (
   input  wire       clock_in,
   input  wire       rst_in,
   input  wire       reg_wr_in,
   input  wire       reg_rd_in,
   input  wire [7:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   output reg  [7:0] reg_rdata_out,
   output reg        reg_ack_out,
   input  wire       alert_mask_in,
   input  wire [1:0] aux_good_in,
   input  wire [1:0] primary_good_in,
   input  wire [1:0] aux_on_in,
   input  wire [1:0] primary_on_in,
   input  wire [1:0] aux_overcurrent_in,
   input  wire [1:0] hv_overcurrent_in,
   input  wire [1:0] lv_overcurrent_in,
   input  wire [1:0] override_pin_n_in,
   input  wire [1:0] power_request_in,
   input  wire [1:0] aux_request_in,
   output reg  [1:0] aux_enable_out,
   output reg  [1:0] primary_enable_out,
   output reg  [1:0] power_ok_oe_n_out,
   output reg  [1:0] trip_pin_oe_n_out,
   output reg        alert_oe_n_out
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // all slot pins are asynchronous; one synchroniser covers the group
   // override enters inverted so the flops' reset zero reads as idle,
   // avoiding a false override in the first cycles after reset
   wire [20:0] pins_s;
   hpsc_sync #(.WIDTH(21)) u_sync (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .async_in ({alert_mask_in, aux_good_in, primary_good_in, aux_on_in,
                  primary_on_in, aux_overcurrent_in, hv_overcurrent_in,
                  lv_overcurrent_in, ~override_pin_n_in, power_request_in,
                  aux_request_in}),
      .sync_out (pins_s)
   );
   wire       mask_s  = pins_s[20];
   wire [1:0] agood_s = pins_s[19:18];
   wire [1:0] pgood_s = pins_s[17:16];
   wire [1:0] aon_s   = pins_s[15:14];
   wire [1:0] pon_s   = pins_s[13:12];
   wire [1:0] aoc_s   = pins_s[11:10];
   wire [1:0] hoc_s   = pins_s[9:8];
   wire [1:0] loc_s   = pins_s[7:6];
   wire [1:0] ovr_s   = ~pins_s[5:4];
   wire [1:0] preq_s  = pins_s[3:2];
   wire [1:0] areq_s  = pins_s[1:0];

   // ------------------------------------------------------------
   // slots
   // ------------------------------------------------------------
   wire [7:0] ctrl_v [0:1];
   wire [7:0] cond_v [0:1];
   wire [1:0] aen, pen, flag_any, ok_oe_n, trip_oe_n;
   wire [1:0] ctrl_wr, cond_wr;
   assign ctrl_wr[0] = reg_wr_in & (reg_addr_in == `HPSC_OFS_CTRL_A);
   assign ctrl_wr[1] = reg_wr_in & (reg_addr_in == `HPSC_OFS_CTRL_B);
   assign cond_wr[0] = reg_wr_in & (reg_addr_in == `HPSC_OFS_COND_A);
   assign cond_wr[1] = reg_wr_in & (reg_addr_in == `HPSC_OFS_COND_B);

   genvar s;
   generate
      for (s = 0; s < 2; s = s + 1)
      begin : g_slot
         hpsc_slot u_slot (
            .clock_in           (clock_in),
            .rst_in             (rst_in),
            .ctrl_wr_in         (ctrl_wr[s]),
            .cond_wr_in         (cond_wr[s]),
            .wdata_in           (reg_wdata_in),
            .aux_good_in        (agood_s[s]),
            .pri_good_in        (pgood_s[s]),
            .aux_on_in          (aon_s[s]),
            .pri_on_in          (pon_s[s]),
            .aux_oc_in          (aoc_s[s]),
            .hv_oc_in           (hoc_s[s]),
            .lv_oc_in           (loc_s[s]),
            .override_n_in      (ovr_s[s]),
            .power_request_in   (preq_s[s]),
            .aux_request_in     (areq_s[s]),
            .ctrl_out           (ctrl_v[s]),
            .cond_out           (cond_v[s]),
            .aux_enable_out     (aen[s]),
            .primary_enable_out (pen[s]),
            .flag_any_out       (flag_any[s]),
            .ok_oe_n_out        (ok_oe_n[s]),
            .trip_oe_n_out      (trip_oe_n[s])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // register read and output flops
   // ------------------------------------------------------------
   reg [7:0] next_rdata;
   always @*
   begin
      case (reg_addr_in)
         `HPSC_OFS_CTRL_A: next_rdata = ctrl_v[0];
         `HPSC_OFS_CTRL_B: next_rdata = ctrl_v[1];
         `HPSC_OFS_COND_A: next_rdata = cond_v[0];
         `HPSC_OFS_COND_B: next_rdata = cond_v[1];
         default:          next_rdata = 8'h00;
      endcase
   end

   always @(posedge clock_in)
   begin
      if (rst_in)
      begin
         reg_rdata_out      <= 8'h00;
         reg_ack_out        <= 1'b0;
         aux_enable_out     <= 2'h0;
         primary_enable_out <= 2'h0;
         power_ok_oe_n_out  <= 2'h3;
         trip_pin_oe_n_out  <= 2'h3;
         alert_oe_n_out     <= 1'b1;
      end
      else
      begin
         if (reg_rd_in)
            reg_rdata_out <= next_rdata;
         reg_ack_out        <= reg_rd_in | reg_wr_in;
         aux_enable_out     <= aen; // RULE1
         primary_enable_out <= pen; // RULE1
         power_ok_oe_n_out  <= ok_oe_n;
         trip_pin_oe_n_out  <= trip_oe_n;
         // alert pulls low on any latched flag unless masked for polling
         alert_oe_n_out     <= ~((|flag_any) & ~mask_s); // RULE17 RULE11
      end
   end
endmodule
`default_nettype wire

/* verif/hpsc_host.sv */
// register bus host model issuing single-byte strobes
`default_nettype none
module hpsc_host (
   input  wire logic       clock_in,
   input  wire logic [7:0] reg_rdata_out,
   input  wire logic       reg_ack_out,
   output var  logic       reg_wr_in,
   output var  logic       reg_rd_in,
   output var  logic [7:0] reg_addr_in,
   output var  logic [7:0] reg_wdata_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
   end
   // strobe is a one-cycle pulse; answer is fixed one cycle later
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
             output logic [7:0] q);
      @(negedge clock_in);
      reg_wr_in = w;
      reg_rd_in = !w;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(negedge clock_in);
      q = (reg_ack_out === 1'b1) ? reg_rdata_out : 8'hxx;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      // scramble released lines so nothing leans on stale values
      reg_addr_in = ~a;
      reg_wdata_in = ~d;
   endtask
endmodule
`default_nettype wire

/* verif/hpsc_top_monitor.sv */
// port assertions for the slot control and status register bank
`default_nettype none
module hpsc_mon (
   input wire logic       clock_in,
   input wire logic       rst_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       alert_mask_in,
   input wire logic [1:0] aux_good_in,
   input wire logic [1:0] primary_good_in,
   input wire logic [1:0] override_pin_n_in,
   input wire logic [1:0] power_request_in,
   input wire logic [1:0] aux_request_in,
   input wire logic [1:0] aux_enable_out,
   input wire logic [1:0] primary_enable_out,
   input wire logic [1:0] power_ok_oe_n_out,
   input wire logic [1:0] trip_pin_oe_n_out,
   input wire logic       alert_oe_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // slot a and bank checks; pins reach the outputs three to five edges late
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   enable_write_a: assert property (reg_wr_in && reg_addr_in == 8'h02 |-> ##2
      aux_enable_out[0] == $past(reg_wdata_in[0], 2)
      && primary_enable_out[0] == $past(reg_wdata_in[1], 2)) else $error("enable mismatch");
   reset_clear_a: assert property (disable iff (1'b0) rst_in |=> aux_enable_out == 2'h0
      && primary_enable_out == 2'h0 && trip_pin_oe_n_out == 2'h3
      && power_ok_oe_n_out == 2'h3 && alert_oe_n_out) else $error("reset state wrong");
   unmapped_zero_a: assert property (reg_rd_in && (reg_addr_in < 8'h02
      || reg_addr_in > 8'h05) |=> reg_rdata_out == 8'h00) else $error("unmapped read");
   reserved_zero_a: assert property (reg_rd_in |=> !reg_rdata_out[3])
      else $error("reserved bit set");
   ok_good_a: assert property ((override_pin_n_in[0] && aux_good_in[0]
      && primary_good_in[0]) [*5] |-> !power_ok_oe_n_out[0]) else $error("ok pin not driven");
   ok_bad_a: assert property ((override_pin_n_in[0] && !aux_good_in[0]) [*5]
      |-> power_ok_oe_n_out[0]) else $error("ok pin driven while not good");
   mask_alert_a: assert property (alert_mask_in [*5] |-> alert_oe_n_out)
      else $error("masked alert driven");
   trip_req_a: assert property ((!power_request_in[0] && !aux_request_in[0]) [*6]
      |-> trip_pin_oe_n_out[0]) else $error("trip without request");
   trip_ovr_a: assert property ((!override_pin_n_in[0]) [*5]
      |-> trip_pin_oe_n_out[0]) else $error("trip under override");
   cover property (reg_wr_in && reg_addr_in == 8'h04);
   cover property (!trip_pin_oe_n_out[0]);
   cover property (!alert_oe_n_out);
endmodule
bind hpsc_top hpsc_mon u_hpsc_mon (.*);
`default_nettype wire

/* verif/hpsc_top_tb_top.sv */
// self-checking bench for the slot control and status registers
`default_nettype none
module hpsc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock_in, rst_in, alert_mask_in;
   logic [1:0] aux_good_in, primary_good_in, aux_on_in, primary_on_in;
   logic [1:0] aux_overcurrent_in, hv_overcurrent_in, lv_overcurrent_in;
   logic [1:0] override_pin_n_in, power_request_in, aux_request_in;
   wire  logic reg_wr_in, reg_rd_in, reg_ack_out, alert_oe_n_out;
   wire  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   wire  logic [1:0] aux_enable_out, primary_enable_out;
   wire  logic [1:0] power_ok_oe_n_out, trip_pin_oe_n_out;
   int         fails, num_checks;
   logic [7:0] q;
   hpsc_top u_hpsc_top (.*);
   hpsc_host u_hpsc_host (.*);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task wrap_up();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      u_hpsc_host.xfer(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      u_hpsc_host.xfer(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   task settle();
      repeat (6) @(negedge clock_in);
   endtask
   task t_reset();
      for (int a = 2; a < 8; a++) rd(8'(a), 8'h00);
      rd(8'hff, 8'h00);
      chk({4'h0, aux_enable_out, primary_enable_out}, 8'h00);
   endtask
   task t_ctrl();
      aux_good_in = 2'h1;
      wr(8'h02, 8'hff);
      wr(8'h03, 8'h02);
      settle();
      rd(8'h02, 8'h87);
      rd(8'h03, 8'h02);
      chk({4'h0, aux_enable_out, primary_enable_out}, 8'h07);
   endtask
   task t_pok();
      primary_good_in = 2'h1;
      settle();
      chk(8'(power_ok_oe_n_out), 8'h02);
      wr(8'h02, 8'h03);
      override_pin_n_in = 2'h2;
      settle();
      chk(8'(power_ok_oe_n_out), 8'h03);
      rd(8'h02, 8'hc3);
      wr(8'h02, 8'h07);
      settle();
      chk(8'(power_ok_oe_n_out), 8'h02);
      override_pin_n_in = 2'h3;
   endtask
   task t_ovr();
      wr(8'h02, 8'h03);
      alert_mask_in = 1'b0;
      aux_request_in = 2'h1;
      aux_overcurrent_in = 2'h1;
      settle();
      aux_overcurrent_in = 2'h0;
      override_pin_n_in = 2'h2;
      settle();
      rd(8'h04, 8'hf0);
      chk({5'h0, alert_oe_n_out, trip_pin_oe_n_out}, 8'h03);
      override_pin_n_in = 2'h3;
      settle();
      chk({5'h0, alert_oe_n_out, trip_pin_oe_n_out}, 8'h02);
      aux_request_in = 2'h0;
      settle();
      chk(8'(trip_pin_oe_n_out), 8'h03);
      wr(8'h04, 8'h10);
      rd(8'h04, 8'h60);
      chk({5'h0, alert_oe_n_out, trip_pin_oe_n_out}, 8'h07);
   endtask
   task t_fault();
      power_request_in = 2'h1;
      aux_request_in = 2'h1;
      aux_on_in = 2'h1;
      primary_on_in = 2'h1;
      lv_overcurrent_in = 2'h1;
      settle();
      lv_overcurrent_in = 2'h0;
      rd(8'h04, 8'he1);
      chk({5'h0, alert_oe_n_out, trip_pin_oe_n_out}, 8'h02);
      wr(8'h04, 8'h01);
      settle();
      rd(8'h04, 8'he0);
      chk({5'h0, alert_oe_n_out, trip_pin_oe_n_out}, 8'h06);
      power_request_in = 2'h0;
      settle();
      rd(8'h04, 8'h60);
      chk(8'(trip_pin_oe_n_out), 8'h03);
      aux_request_in = 2'h0;
      alert_mask_in = 1'b1;
      hv_overcurrent_in = 2'h1;
      settle();
      hv_overcurrent_in = 2'h0;
      rd(8'h04, 8'h64);
      chk({5'h0, alert_oe_n_out, trip_pin_oe_n_out}, 8'h07);
      wr(8'h04, 8'h04);
      rd(8'h04, 8'h60);
   endtask
   // ------------------------------------------------------------
   // clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial
   begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end
   initial
   begin
      #50us;
      fails++;
      wrap_up();
   end
   initial
   begin
      {rst_in, alert_mask_in} = 2'b10;
      {aux_good_in, primary_good_in, aux_on_in, primary_on_in} = 8'h00;
      {aux_overcurrent_in, hv_overcurrent_in, lv_overcurrent_in} = 6'h00;
      {power_request_in, aux_request_in} = 4'h0;
      override_pin_n_in = 2'h3;
      fails = 0;
      num_checks = 0;
      repeat (3) @(negedge clock_in);
      rst_in = 1'b0;
      t_reset();
      t_ctrl();
      t_pok();
      t_fault();
      t_ovr();
      wrap_up();
   end
endmodule
`default_nettype wire
